// file: core/fsw_params.svh
// Constants for the status, protection and lock decode block
`ifndef FSW_PARAMS_SVH
`define FSW_PARAMS_SVH
`define FSW_OP_WR_SR1 8'h01
`define FSW_OP_PROG 8'h02
`define FSW_OP_RD_SR1 8'h05
`define FSW_OP_WR_SR3 8'h11
`define FSW_OP_RD_SR3 8'h15
`define FSW_OP_SECT_ER 8'h20
`define FSW_OP_WR_SR2 8'h31
`define FSW_OP_RD_SR2 8'h35
`define FSW_OP_LOCK 8'h36
`define FSW_OP_UNLOCK 8'h39
`define FSW_OP_SEC_PROG 8'h42
`define FSW_OP_SEC_ER 8'h44
`define FSW_OP_CHIP_ER1 8'h60
`define FSW_OP_SUSPEND 8'h75
`define FSW_OP_RESUME 8'h7A
`define FSW_OP_CHIP_ER2 8'hC7
`define FSW_OP_BLK_ER 8'hD8
`define FSW_BIT_SUS 7
`define FSW_BIT_CMP 6
`define FSW_BIT_LB_HI 5
`define FSW_BIT_LB_LO 3
`define FSW_BIT_QE 1
`define FSW_BIT_SEC 6
`define FSW_BIT_TB 5
`define FSW_BIT_BP_HI 4
`define FSW_BIT_BP_LO 2
`define FSW_BIT_WPS 2
`define FSW_BIT_DRV_HI 6
`define FSW_BIT_DRV_LO 5
`define FSW_RST_DRV 2'h3
`define FSW_RST_LB 3'h0
`define FSW_RST_LOCK 1'b1
`define FSW_TOP_ADDR 24'h7FFFFF
`define FSW_ARRAY_END 24'h800000
`define FSW_BLK_UNIT 24'h020000
`define FSW_SECT_UNIT 24'h001000
`define FSW_SECT_MAX 24'h008000
`define FSW_PAGE_MASK 24'h0000FF
`define FSW_SECT_MASK 24'h000FFF
`define FSW_BLK_MASK 24'h00FFFF
`define FSW_N_LOCKS 158
`define FSW_LOCK_TOP 16
`define FSW_LOCK_MID 32
`define FSW_LAST_BLK 7'h7F
`define FSW_PCT_100 7'h64
`define FSW_PCT_75 7'h4B
`define FSW_PCT_50 7'h32
`define FSW_PCT_25 7'h19
`define FSW_CNT_MAX 6'h3F
`endif

// file: core/fsw_pkg.sv
// Types shared by the status and protection decode block
package fsw_pkg;
    typedef enum logic [2:0] {
        FSW_PROG = 3'b000,
        FSW_SECT = 3'b001,
        FSW_BLK = 3'b010,
        FSW_CHIP = 3'b011,
        FSW_SPROG = 3'b100,
        FSW_SERASE = 3'b101
    } fsw_kind_e;

    typedef struct packed {
        logic valid;
        logic [23:0] lo;
        logic [23:0] hi;
    } fsw_range_s;

    typedef struct packed {
        fsw_kind_e kind;
        logic [23:0] addr;
    } fsw_req_s;
endpackage

// file: core/fsw_ctrl.sv
// Serial status registers, region decoder and program/erase gate
`timescale 1ns/1ns
`include "fsw_params.svh"
module fsw_ctrl (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic io0_i,
    output logic io1_o,
    output logic io1_oe,
    input wire logic io2_i,
    output logic io2_o,
    output logic io2_oe,
    input wire logic io3_i,
    output logic io3_o,
    output logic io3_oe,
    input wire logic quad_drive,
    output logic pause_active,
    output logic quad_mode,
    output logic pe_go,
    output fsw_pkg::fsw_req_s pe_req,
    output logic pe_ignored,
    output logic [6:0] drive_pct,
    output fsw_pkg::fsw_range_s prot_map,
    output logic [7:0] status_hi,
    output logic [7:0] status_third
);
    localparam int CS = 0;
    localparam int SCK = 1;
    localparam int DI = 2;
    localparam int HLD = 3;

    logic [3:0] s1_ff;
    logic [3:0] s2_ff;
    logic [1:0] prv_ff;
    logic [5:0] cnt_ff;
    logic [31:0] sh_ff;
    logic [7:0] op_ff;
    logic [23:0] addr_ff;
    logic [7:0] out_ff;
    logic rd_ff;
    logic do_ff;
    logic sus_ff;
    logic cmp_ff;
    logic [2:0] lb_ff;
    logic qe_ff;
    logic sec_ff;
    logic tb_ff;
    logic [2:0] bp_ff;
    logic wps_ff;
    logic [1:0] drv_ff;
    logic [`FSW_N_LOCKS-1:0] lock_ff;
    logic pe_go_ff;
    logic pe_ign_ff;
    fsw_pkg::fsw_req_s req_ff;
    logic paused;
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic cs_fall;
    logic [7:0] op_now;
    logic [7:0] sr1_rd;
    logic [7:0] sr2_rd;
    logic [7:0] sr3_rd;
    logic done;
    logic sr1_we;
    logic sr2_we;
    logic sr3_we;
    logic [7:0] sr1_wd;
    logic [7:0] sr2_wd;
    logic pe_cmd;
    fsw_pkg::fsw_kind_e pe_kind;
    logic pe_blk;

    // Region chosen by granularity, bottom select and size code
    function automatic fsw_pkg::fsw_range_s decode(input logic sec, input logic tb,
                                                   input logic [2:0] bp);
        fsw_pkg::fsw_range_s r;
        logic [23:0] size;
        r.valid = (bp != 3'h0);
        size = `FSW_ARRAY_END;
        if (bp != 3'h7 && !sec) begin
            size = `FSW_BLK_UNIT << (bp - 3'h1);
        end else if (bp != 3'h7 && bp[2]) begin
            size = `FSW_SECT_MAX;
        end else if (bp != 3'h7) begin
            size = `FSW_SECT_UNIT << (bp - 3'h1);
        end
        if (tb) begin
            r.lo = 24'h000000;
            r.hi = size - 24'h000001;
        end else begin
            r.lo = `FSW_ARRAY_END - size;
            r.hi = `FSW_TOP_ADDR;
        end
        return r;
    endfunction

    // Index of the individual lock covering an address
    function automatic logic [7:0] lock_idx(input logic [23:0] a);
        logic [6:0] b;
        b = a[22:16];
        if (b == 7'h00) begin
            return {4'h0, a[15:12]};
        end else if (b == `FSW_LAST_BLK) begin
            return 8'(`FSW_LOCK_TOP) + {4'h0, a[15:12]};
        end
        return 8'(`FSW_LOCK_MID) + {1'b0, b} - 8'h01;
    endfunction

    // Byte range touched by a command
    function automatic logic [47:0] span(input fsw_pkg::fsw_kind_e k,
                                         input logic [23:0] a);
        logic [23:0] m;
        unique case (k)
            fsw_pkg::FSW_PROG: m = `FSW_PAGE_MASK;
            fsw_pkg::FSW_SECT: m = `FSW_SECT_MASK;
            fsw_pkg::FSW_BLK: m = `FSW_BLK_MASK;
            default: m = `FSW_TOP_ADDR;
        endcase
        return {a & ~m & `FSW_TOP_ADDR, (a | m) & `FSW_TOP_ADDR};
    endfunction

    // Input synchronisers, the first stage feeds only the second
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1_ff <= 4'hF;
            s2_ff <= 4'hF;
            prv_ff <= 2'h3;
        end else begin
            s1_ff <= {io3_i, io0_i, sclk, cs_n};
            s2_ff <= s1_ff;
            prv_ff <= s2_ff[1:0];
        end
    end

    // Pause pin acts only while quad mode is off
    assign paused = !qe_ff && !s2_ff[HLD];
    assign sck_rise = s2_ff[SCK] && !prv_ff[SCK] && !s2_ff[CS] && !paused;
    assign sck_fall = !s2_ff[SCK] && prv_ff[SCK] && !s2_ff[CS] && !paused;
    assign cs_rise = s2_ff[CS] && !prv_ff[CS];
    assign cs_fall = !s2_ff[CS] && prv_ff[CS];
    assign op_now = {sh_ff[6:0], s2_ff[DI]};

    // Bit counter and input shifter
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= 6'h00;
            sh_ff <= 32'h00000000;
        end else if (cs_fall) begin
            cnt_ff <= 6'h00;
            sh_ff <= 32'h00000000;
        end else if (sck_rise) begin
            sh_ff <= {sh_ff[30:0], s2_ff[DI]};
            if (cnt_ff != `FSW_CNT_MAX) begin
                cnt_ff <= cnt_ff + 6'h01;
            end
        end
    end

    // Opcode and address capture
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            op_ff <= 8'h00;
            addr_ff <= 24'h000000;
        end else if (sck_rise && cnt_ff == 6'h07) begin
            op_ff <= op_now;
        end else if (sck_rise && cnt_ff == 6'h1F) begin
            addr_ff <= {sh_ff[22:0], s2_ff[DI]};
        end
    end

    assign sr1_rd = {1'b0, sec_ff, tb_ff, bp_ff, 2'h0};
    assign sr2_rd = {sus_ff, cmp_ff, lb_ff, 1'b0, qe_ff, 1'b0};
    assign sr3_rd = {1'b0, drv_ff, 2'h0, wps_ff, 2'h0};

    // Status read: byte repeats while chip select stays low
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_ff <= 1'b0;
            out_ff <= 8'h00;
            do_ff <= 1'b0;
        end else if (s2_ff[CS]) begin
            rd_ff <= 1'b0;
        end else if (sck_rise && cnt_ff == 6'h07) begin
            rd_ff <= 1'b1;
            unique case (op_now)
                `FSW_OP_RD_SR1: out_ff <= sr1_rd;
                `FSW_OP_RD_SR2: out_ff <= sr2_rd;
                `FSW_OP_RD_SR3: out_ff <= sr3_rd;
                default: rd_ff <= 1'b0;
            endcase
        end else if (sck_fall && rd_ff) begin
            do_ff <= out_ff[7];
            out_ff <= {out_ff[6:0], out_ff[7]};
        end
    end

    // Decode of a finished instruction at chip select release
    assign done = cs_rise && cnt_ff[2:0] == 3'h0 && cnt_ff != 6'h00;
    always_comb begin
        sr1_we = 1'b0;
        sr2_we = 1'b0;
        sr3_we = 1'b0;
        sr1_wd = sh_ff[7:0];
        sr2_wd = sh_ff[7:0];
        pe_cmd = 1'b0;
        pe_kind = fsw_pkg::FSW_PROG;
        if (done) begin
            unique case (op_ff)
                `FSW_OP_WR_SR1: begin
                    sr1_we = (cnt_ff == 6'h10 || cnt_ff == 6'h18);
                    sr2_we = (cnt_ff == 6'h18);
                    sr1_wd = (cnt_ff == 6'h18) ? sh_ff[15:8] : sh_ff[7:0];
                end
                `FSW_OP_WR_SR2: sr2_we = (cnt_ff == 6'h10);
                `FSW_OP_WR_SR3: sr3_we = (cnt_ff == 6'h10);
                `FSW_OP_PROG: begin
                    pe_cmd = (cnt_ff >= 6'h28);
                end
                `FSW_OP_SECT_ER: begin
                    pe_cmd = (cnt_ff == 6'h20);
                    pe_kind = fsw_pkg::FSW_SECT;
                end
                `FSW_OP_BLK_ER: begin
                    pe_cmd = (cnt_ff == 6'h20);
                    pe_kind = fsw_pkg::FSW_BLK;
                end
                `FSW_OP_CHIP_ER1, `FSW_OP_CHIP_ER2: begin
                    pe_cmd = (cnt_ff == 6'h08);
                    pe_kind = fsw_pkg::FSW_CHIP;
                end
                `FSW_OP_SEC_PROG: begin
                    pe_cmd = (cnt_ff >= 6'h28);
                    pe_kind = fsw_pkg::FSW_SPROG;
                end
                `FSW_OP_SEC_ER: begin
                    pe_cmd = (cnt_ff == 6'h20);
                    pe_kind = fsw_pkg::FSW_SERASE;
                end
                default: pe_cmd = 1'b0;
            endcase
        end
    end

    // Protection check for the command being committed
    always_comb begin
        logic [47:0] sp;
        logic [7:0] ix;
        logic enclosed;
        logic touch;
        logic [1:0] rg;
        sp = span(pe_kind, addr_ff);
        ix = lock_idx(addr_ff);
        enclosed = prot_map.valid && sp[47:24] >= prot_map.lo && sp[23:0] <= prot_map.hi;
        touch = prot_map.valid && !(sp[23:0] < prot_map.lo || sp[47:24] > prot_map.hi);
        rg = addr_ff[13:12];
        if (pe_kind == fsw_pkg::FSW_SPROG || pe_kind == fsw_pkg::FSW_SERASE) begin
            pe_blk = (rg == 2'h0) || lb_ff[rg - 2'h1];
        end else if (!wps_ff) begin
            pe_blk = cmp_ff ? !enclosed : touch;
        end else if (pe_kind == fsw_pkg::FSW_CHIP) begin
            pe_blk = |lock_ff;
        end else if (pe_kind == fsw_pkg::FSW_BLK && ix < 8'(`FSW_LOCK_MID)) begin
            pe_blk = |lock_ff[ix & 8'hF0 +: 16];
        end else begin
            pe_blk = lock_ff[ix];
        end
    end

    // Suspend flag, read-only to the host
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sus_ff <= 1'b0;
        end else if (done && cnt_ff == 6'h08 && op_ff == `FSW_OP_SUSPEND) begin
            sus_ff <= 1'b1;
        end else if (done && cnt_ff == 6'h08 && op_ff == `FSW_OP_RESUME) begin
            sus_ff <= 1'b0;
        end
    end

    // Second status byte: complement, one-time locks, quad enable
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cmp_ff <= 1'b0;
            lb_ff <= `FSW_RST_LB;
            qe_ff <= 1'b0;
        end else if (sr2_we) begin
            cmp_ff <= sr2_wd[`FSW_BIT_CMP];
            lb_ff <= lb_ff | sr2_wd[`FSW_BIT_LB_HI:`FSW_BIT_LB_LO];
            qe_ff <= sr2_wd[`FSW_BIT_QE];
        end
    end

    // First status byte: granularity, bottom select, size code
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sec_ff <= 1'b0;
            tb_ff <= 1'b0;
            bp_ff <= 3'h0;
        end else if (sr1_we) begin
            sec_ff <= sr1_wd[`FSW_BIT_SEC];
            tb_ff <= sr1_wd[`FSW_BIT_TB];
            bp_ff <= sr1_wd[`FSW_BIT_BP_HI:`FSW_BIT_BP_LO];
        end
    end

    // Third status byte: scheme select and drive strength
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wps_ff <= 1'b0;
            drv_ff <= `FSW_RST_DRV;
        end else if (sr3_we) begin
            wps_ff <= sh_ff[`FSW_BIT_WPS];
            drv_ff <= sh_ff[`FSW_BIT_DRV_HI:`FSW_BIT_DRV_LO];
        end
    end

    // Individual sector and block locks
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lock_ff <= {`FSW_N_LOCKS{`FSW_RST_LOCK}};
        end else if (done && cnt_ff == 6'h20 && op_ff == `FSW_OP_UNLOCK) begin
            lock_ff[lock_idx(sh_ff[23:0])] <= 1'b0;
        end else if (done && cnt_ff == 6'h20 && op_ff == `FSW_OP_LOCK) begin
            lock_ff[lock_idx(sh_ff[23:0])] <= 1'b1;
        end
    end

    // Program/erase hand-off: start pulse or ignored pulse
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pe_go_ff <= 1'b0;
            pe_ign_ff <= 1'b0;
            req_ff <= '0;
        end else begin
            pe_go_ff <= pe_cmd && !pe_blk;
            pe_ign_ff <= pe_cmd && pe_blk;
            if (pe_cmd) begin
                req_ff <= '{kind: pe_kind, addr: addr_ff};
            end
        end
    end

    // Drive strength decode
    always_comb begin
        unique case (drv_ff)
            2'h0: drive_pct = `FSW_PCT_100;
            2'h1: drive_pct = `FSW_PCT_75;
            2'h2: drive_pct = `FSW_PCT_50;
            2'h3: drive_pct = `FSW_PCT_25;
        endcase
    end

    // Live region map, follows register bits without delay
    assign prot_map = decode(sec_ff, tb_ff, bp_ff);

    // Lines 2 and 3 are driven only in quad mode
    assign io2_o = io2_i & 1'b0;
    assign io3_o = 1'b0;
    assign io2_oe = qe_ff && quad_drive && !s2_ff[CS];
    assign io3_oe = qe_ff && quad_drive && !s2_ff[CS];
    assign io1_o = do_ff;
    assign io1_oe = rd_ff && !s2_ff[CS];
    assign pause_active = paused;
    assign quad_mode = qe_ff;
    assign pe_go = pe_go_ff;
    assign pe_ignored = pe_ign_ff;
    assign pe_req = req_ff;
    assign status_hi = sr2_rd;
    assign status_third = sr3_rd;
endmodule

// file: verif/fsw_chk.sv
// Assertion checker for the status and protection decode block
`timescale 1ns/1ns
module fsw_chk (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic io3_i,
    input wire logic quad_drive,
    input wire logic io2_oe,
    input wire logic io2_o,
    input wire logic io3_o,
    input wire logic io3_oe,
    input wire logic pause_active,
    input wire logic quad_mode,
    input wire logic pe_go,
    input wire logic pe_ignored,
    input wire fsw_pkg::fsw_req_s pe_req,
    input wire logic [6:0] drive_pct,
    input wire fsw_pkg::fsw_range_s prot_map,
    input wire logic [7:0] status_hi,
    input wire logic [7:0] status_third
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Gate outcomes are exclusive single-cycle pulses
    chk_pulse_excl: assert property ((pe_go || pe_ignored) |-> !(pe_go && pe_ignored) ##1
        !(pe_go || pe_ignored)) else $error("gate pulse overlap or too long");
    chk_req_hold: assert property (!$stable(pe_req) |-> pe_go || pe_ignored)
        else $error("request changed without a gate pulse");
    // Lines 2 and 3 follow chip select after its two-stage synchroniser
    chk_quad_oe: assert property (io2_oe == (quad_mode && quad_drive &&
        !$past(cs_n, 2)) && io3_oe == io2_oe && !io2_o && !io3_o)
        else $error("line 2 or 3 drive wrong");
    chk_pause_off: assert property (quad_mode |-> !pause_active)
        else $error("pause active in quad mode");
    chk_pause_on: assert property ((!quad_mode && !io3_i) [*4] |-> pause_active)
        else $error("pause not active");
    chk_drive_map: assert property (drive_pct == (status_third[6:5] == 2'h0 ? 7'h64 :
        status_third[6:5] == 2'h1 ? 7'h4B : status_third[6:5] == 2'h2 ? 7'h32 : 7'h19))
        else $error("drive strength decode wrong");
    chk_rsv_zero: assert property ({status_hi[2], status_hi[0], status_third[7],
        status_third[4:3], status_third[1:0]} == 7'h00) else $error("reserved bit set");
    chk_lock_sticky: assert property (($past(status_hi) & ~status_hi & 8'h38) == 8'h00)
        else $error("lock bit cleared");
    chk_qe_mode: assert property (quad_mode == status_hi[1])
        else $error("quad mode differs from register");
    chk_map_shape: assert property (prot_map.valid |-> (prot_map.lo == 24'h000000 ||
        prot_map.hi == 24'h7FFFFF) && prot_map.lo[11:0] == 12'h000 && prot_map.hi[11:0] == 12'hFFF)
        else $error("protected range shape wrong");
    chk_stat_hold: assert property ((!cs_n) [*6] |->
        $stable(status_hi) && $stable(status_third))
        else $error("status changed inside a frame");
    // Main scenarios
    cov_go: cover property (pe_go);
    cov_ign: cover property (pe_ignored);
    cov_pause: cover property (pause_active);
endmodule

bind fsw_ctrl fsw_chk u_chk (.ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .io3_i(io3_i),
    .quad_drive(quad_drive), .io2_oe(io2_oe), .io2_o(io2_o), .io3_o(io3_o),
    .io3_oe(io3_oe), .pause_active(pause_active),
    .quad_mode(quad_mode), .pe_go(pe_go), .pe_ignored(pe_ignored), .pe_req(pe_req),
    .drive_pct(drive_pct), .prot_map(prot_map), .status_hi(status_hi),
    .status_third(status_third));

// file: verif/fsw_host.sv
// Serial host model that sends instruction frames to the block
`timescale 1ns/1ns
module fsw_host (
    output logic cs_n,
    output logic sclk,
    output logic io0,
    input wire logic io1
);
    // Idle bus: deselected, clock low
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        io0 = 1'b0;
    end
    // Whole frame MSB first at a 125 ns bit time; keeps the last eight bits read
    task automatic xfer(input logic [63:0] d, input int n, output logic [7:0] rd);
        int i;
        rd = 8'h00;
        cs_n = 1'b0;
        #61; // Offset keeps every link edge off the sampling clock edges
        for (i = 0; i < n; i++) begin
            io0 = d[n - 1 - i];
            #62;
            sclk = 1'b1;
            rd = {rd[6:0], io1};
            #63;
            sclk = 1'b0;
        end
        #62;
        cs_n = 1'b1;
        io0 = ~io0;
        #63;
    endtask
endmodule

// file: verif/fsw_ctrl_tb_top.sv
// Testbench for the status and protection decode block
`timescale 1ns/1ns
module fsw_ctrl_tb_top;
    logic ref_clk, rst, cs_n, sclk, io0, io1_o, io1_oe, io1_w, io2_i, io2_o, io2_oe;
    logic io3_i, io3_o, io3_oe, quad_drive, pause_active, quad_mode, pe_go, pe_ignored;
    logic [6:0] drive_pct;
    logic [7:0] status_hi, status_third, rd;
    fsw_pkg::fsw_req_s pe_req, last_req;
    fsw_pkg::fsw_range_s prot_map;
    int fail_count, num_checks, n_go, n_ign;

    fsw_ctrl uut (.ref_clk(ref_clk), .rst(rst), .cs_n(cs_n), .sclk(sclk), .io0_i(io0),
        .io1_o(io1_o), .io1_oe(io1_oe), .io2_i(io2_i), .io2_o(io2_o), .io2_oe(io2_oe),
        .io3_i(io3_i), .io3_o(io3_o), .io3_oe(io3_oe), .quad_drive(quad_drive),
        .pause_active(pause_active), .quad_mode(quad_mode), .pe_go(pe_go), .pe_req(pe_req),
        .pe_ignored(pe_ignored), .drive_pct(drive_pct), .prot_map(prot_map),
        .status_hi(status_hi), .status_third(status_third));
    fsw_host host (.cs_n(cs_n), .sclk(sclk), .io0(io0), .io1(io1_w));

    // Undriven data line shows the inverse of its last value
    assign io1_w = io1_oe ? io1_o : ~io1_o;

    // 100 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Catch the one-cycle gate pulses mid-cycle, where they are settled
    always @(negedge ref_clk) begin
        if (pe_go === 1'b1) begin
            n_go++;
            last_req = pe_req;
        end
        if (pe_ignored === 1'b1) n_ign++;
    end

    task automatic compare(input logic [48:0] exp, input logic [48:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // One frame, then let the instruction take effect
    task automatic cmd(input logic [63:0] d, input int n);
        host.xfer(d, n, rd);
        repeat (8) @(negedge ref_clk);
    endtask

    // Program or erase, judged by which pulse came and, for a start pulse, the request it carried
    task automatic pe(input logic [7:0] op, input logic [23:0] a,
                      input fsw_pkg::fsw_kind_e k, input logic go);
        n_go = 0;
        n_ign = 0;
        if (k == fsw_pkg::FSW_SPROG) cmd({op, a, 8'hA5}, 40);
        else cmd({op, a}, 32);
        compare({n_go[1:0], n_ign[1:0]}, {1'b0, go, 1'b0, !go});
        if (go) compare({k, a}, last_req);
    endtask

    task automatic pulse_rst();
        @(negedge ref_clk);
        rst = 1'b1;
        repeat (6) @(negedge ref_clk);
        rst = 1'b0;
        repeat (3) @(negedge ref_clk);
    endtask

    function automatic logic [48:0] exp_map(input logic sec, input logic tb, input logic [2:0] bp);
        logic [23:0] sz;
        if (bp == 3'h0) return 49'h0;
        if (bp == 3'h7) return {1'b1, 24'h000000, 24'h7FFFFF};
        sz = sec ? (24'h001000 << ((bp > 3'h4 ? 3'h4 : bp) - 3'h1)) : (24'h020000 << (bp - 3'h1));
        return tb ? {1'b1, 24'h000000, sz - 24'h1} : {1'b1, 24'h800000 - sz, 24'h7FFFFF};
    endfunction

    task automatic t_reset();
        compare({8'h00, 8'h60, 7'h19, 1'b0}, {status_hi, status_third, drive_pct, prot_map.valid});
        cmd({8'h35, 8'h00}, 16);
        compare(8'h00, rd);
        cmd({8'h15, 8'h00}, 16);
        compare(8'h60, rd);
    endtask

    task automatic t_suspend();
        cmd(8'h75, 8);
        cmd({8'h35, 8'h00}, 16);
        compare(8'h80, rd);
        cmd(8'h7A, 8);
        compare(8'h00, status_hi);
    endtask

    task automatic t_otp();
        cmd({8'h31, 8'h08}, 16);
        compare(8'h08, status_hi);
        pe(8'h42, 24'h001000, fsw_pkg::FSW_SPROG, 1'b0);
        pe(8'h42, 24'h002000, fsw_pkg::FSW_SPROG, 1'b1);
        cmd({8'h31, 8'hFF}, 16);
        compare(8'h7A, status_hi);
        cmd({8'h31, 8'h00}, 16);
        compare(8'h38, status_hi);
        pe(8'h42, 24'h002000, fsw_pkg::FSW_SPROG, 1'b0);
    endtask

    task automatic t_quad();
        quad_drive = 1'b1;
        cmd({8'h31, 8'h3A}, 16);
        compare(1'b1, quad_mode);
        io3_i = 1'b0;
        repeat (5) @(negedge ref_clk);
        compare(1'b0, pause_active);
        cmd({8'h31, 8'h38}, 16);
        compare({1'b0, 1'b1}, {quad_mode, pause_active});
        cmd({8'h31, 8'h3A}, 16);
        compare(8'h38, status_hi);
        io3_i = 1'b1;
        quad_drive = 1'b0;
        repeat (5) @(negedge ref_clk);
        compare(1'b0, pause_active);
    endtask

    task automatic t_drive();
        logic [6:0] pct [4] = '{7'h64, 7'h4B, 7'h32, 7'h19};
        for (int i = 0; i < 4; i++) begin
            cmd({8'h11, 1'b0, i[1:0], 5'h00}, 16);
            compare({pct[i], 1'b0, i[1:0], 5'h00}, {drive_pct, status_third});
        end
    endtask

    task automatic t_decode();
        for (int i = 0; i < 32; i++) begin
            cmd({8'h01, 1'b0, i[4:0], 2'b00}, 16);
            compare(exp_map(i[4], i[3], i[2:0]), (i[2:0] == 3'h0) ? {prot_map.valid, 48'h0} :
                prot_map);
        end
    endtask

    task automatic t_gate();
        cmd({8'h01, 8'h44}, 16);
        pe(8'h20, 24'h7FE000, fsw_pkg::FSW_SECT, 1'b1);
        pe(8'hD8, 24'h7F0000, fsw_pkg::FSW_BLK, 1'b0);
        cmd({8'h31, 8'h78}, 16);
        pe(8'h20, 24'h7FF000, fsw_pkg::FSW_SECT, 1'b1);
        pe(8'h20, 24'h7FE000, fsw_pkg::FSW_SECT, 1'b0);
        cmd({8'h11, 8'h64}, 16);
        pe(8'h20, 24'h7FE000, fsw_pkg::FSW_SECT, 1'b0);
        cmd({8'h39, 24'h7FE000}, 32);
        pe(8'h20, 24'h7FE000, fsw_pkg::FSW_SECT, 1'b1);
        pe(8'h20, 24'h7FF000, fsw_pkg::FSW_SECT, 1'b0);
    endtask

    task automatic t_power();
        cmd(8'h75, 8);
        pulse_rst();
        compare({8'h00, 8'h60}, {status_hi, status_third});
        cmd({8'h11, 8'h64}, 16);
        pe(8'h20, 24'h7FE000, fsw_pkg::FSW_SECT, 1'b0);
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        io2_i = 1'b0;
        io3_i = 1'b1;
        quad_drive = 1'b0;
        repeat (6) @(negedge ref_clk);
        rst = 1'b0;
        repeat (3) @(negedge ref_clk);
        t_reset();
        t_suspend();
        t_otp();
        t_quad();
        t_drive();
        t_decode();
        t_gate();
        t_power();
        results();
    end

    // Watchdog well beyond the expected run
    initial begin
        #500000;
        fail_count++;
        results();
    end
endmodule
